/* File: pkg/rmsc_pkg.sv */
package rmsc_pkg;

    localparam int RMSC_AW = 8;
    localparam int RMSC_DW = 16;
    localparam int RMSC_FRAME_BITS = 24;

    // Register offsets
    localparam logic [7:0] RMSC_OFS_SOFT_RESET = 8'h00;
    localparam logic [7:0] RMSC_OFS_POWER = 8'h01;
    localparam logic [7:0] RMSC_OFS_INT = 8'h02;
    localparam logic [7:0] RMSC_OFS_FRAC = 8'h03;
    localparam logic [7:0] RMSC_OFS_MOD = 8'h04;
    localparam logic [7:0] RMSC_OFS_PUMP = 8'h20;
    localparam logic [7:0] RMSC_OFS_REF = 8'h21;
    localparam logic [7:0] RMSC_OFS_OSC = 8'h22;
    localparam logic [7:0] RMSC_OFS_RFIN = 8'h23;

    // Reset values
    localparam logic [15:0] RMSC_RST_POWER = 16'h8B7F;
    localparam logic [15:0] RMSC_RST_INT = 16'h0058;
    localparam logic [15:0] RMSC_RST_FRAC = 16'h0250;
    localparam logic [15:0] RMSC_RST_MOD = 16'h0600;
    localparam logic [15:0] RMSC_RST_PUMP = 16'h0C26;
    localparam logic [15:0] RMSC_RST_REF = 16'h0003;
    localparam logic [15:0] RMSC_RST_OSC = 16'h000A;
    localparam logic [15:0] RMSC_RST_RFIN = 16'h0000;

    // Field positions
    localparam int RMSC_B_SOFT_RESET = 0;
    localparam int RMSC_B_LO_REG = 15;
    localparam int RMSC_B_IF_AMP = 11;
    localparam int RMSC_B_MIXER = 9;
    localparam int RMSC_B_EXT_LO = 8;
    localparam int RMSC_B_LO_DRV = 7;
    localparam int RMSC_B_DIV_MODE = 11;
    localparam int RMSC_B_BLEED_DIR = 5;
    localparam int RMSC_B_POLARITY = 3;
    localparam int RMSC_B_SW_SRC = 11;

    typedef struct packed {
        logic lo_regulator_power;
        logic if_amp_power;
        logic mixer_power;
        logic external_lo_path_power;
        logic lo_driver_power;
        logic reference_buffer_power;
        logic oscillator_power;
        logic divider_power;
        logic pump_power;
        logic oscillator_regulator_power;
        logic main_regulator_power;
    } rmsc_power_t;

    typedef struct packed {
        logic integer_mode;
        logic [10:0] integer_word;
        logic [10:0] fraction_numerator_word;
        logic [10:0] modulus_word;
    } rmsc_divider_t;

    typedef struct packed {
        logic [3:0] pump_coarse_current;
        logic bleed_source;
        logic [4:0] bleed_step;
        logic [2:0] reference_output_select;
        logic detector_polarity;
        logic [2:0] reference_input_scale;
        logic [1:0] lo_drive_amplitude;
        logic [1:0] lo_output_divide;
        logic [2:0] lo_source_select;
    } rmsc_synth_t;

    typedef struct packed {
        logic input_switch_control_source;
        logic [1:0] input_switch_select;
        logic [3:0] rf_attenuation_step;
        logic [4:0] if_attenuation_step;
    } rmsc_rfin_t;

endpackage : rmsc_pkg

/* File: src/rmsc_regs.sv */
`timescale 1ns/1ps
// Function
// - Write bit0 of 0x00 fires soft reset
// - Power enables reset to 0x8B7F
// - Bit15 powers LO regulator
// - Bit11 enables IF amplifier
// - Bit9 mixer, bit8 external LO path
// - Bits0-5 power individual synthesizer blocks
// - 0x02 bit11 selects integer mode
// - 0x02 holds integer word, reset 0x58
// - 0x03 holds fraction numerator, reset 0x250
// - 0x04 holds modulus, reset 0x600
// - Pump coarse current thermometer code, reset 0011
// - Bleed current step field, reset 6
// - Bleed direction bit, reset source
// - Reference output pin source select
// - Detector polarity bit, reset positive
// - Reference input scale, reset divide 4
// - LO drive amplitude, reset code 00
// - LO output divide, reset divide 2
// - LO source select, reset code 010
// - Switch follows serial or pins
// - Selects one of four RF inputs
// - RF attenuator in 1 dB steps
// - IF attenuation code field
module rmsc_regs
    import rmsc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdio,
    input wire logic [1:0] i_switch_pins,
    output logic o_spi_sdio,
    output logic o_spi_sdio_oe_n,
    output logic o_soft_reset,
    output rmsc_power_t o_power,
    output rmsc_divider_t o_divider,
    output rmsc_synth_t o_synth,
    output rmsc_rfin_t o_rfin,
    output logic [1:0] o_rf_input_active
);

    typedef enum logic [2:0] {
        RMSC_ST_IDLE = 3'b001,
        RMSC_ST_SHIFT = 3'b010,
        RMSC_ST_DRIVE = 3'b100
    } rmsc_state_t;

    // Serial framing: bit23 read/write (1 = read), 7-bit address, 16 data bits, MSB first
    rmsc_state_t state_r, state_nxt;
    logic sclk_d_r, sclk_d_nxt;
    logic [4:0] count_r, count_nxt;
    logic [23:0] shift_r, shift_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic out_r, out_nxt;
    logic commit_r, commit_nxt;
    logic soft_r, soft_nxt;

    logic [15:0] pwr_r, pwr_nxt;
    logic [15:0] int_r, int_nxt;
    logic [15:0] frac_r, frac_nxt;
    logic [15:0] mod_r, mod_nxt;
    logic [15:0] pump_r, pump_nxt;
    logic [15:0] ref_r, ref_nxt;
    logic [15:0] osc_r, osc_nxt;
    logic [15:0] rfin_r, rfin_nxt;

    logic rise;
    logic fall;
    logic [7:0] addr;
    logic [7:0] raddr;
    logic [15:0] wdata;
    logic [15:0] rmux;

    assign rise = i_spi_sclk && !sclk_d_r;
    assign fall = !i_spi_sclk && sclk_d_r;
    assign addr = {1'b0, shift_r[22:16]};
    // Read frames stop shifting after the address, so it sits in the low byte
    assign raddr = {1'b0, shift_r[6:0]};
    assign wdata = shift_r[15:0];

    always_comb begin
        case (raddr)
            RMSC_OFS_POWER: rmux = pwr_r;
            RMSC_OFS_INT: rmux = int_r;
            RMSC_OFS_FRAC: rmux = frac_r;
            RMSC_OFS_MOD: rmux = mod_r;
            RMSC_OFS_PUMP: rmux = pump_r;
            RMSC_OFS_REF: rmux = ref_r;
            RMSC_OFS_OSC: rmux = osc_r;
            RMSC_OFS_RFIN: rmux = rfin_r;
            default: rmux = 16'h0000;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        sclk_d_nxt = i_spi_sclk;
        count_nxt = count_r;
        shift_nxt = shift_r;
        rd_nxt = rd_r;
        out_nxt = out_r;
        commit_nxt = 1'b0;
        if (i_spi_cs_n) begin
            state_nxt = RMSC_ST_IDLE;
            count_nxt = 5'h00;
            out_nxt = 1'b0;
        end else begin
            case (state_r)
                RMSC_ST_IDLE: begin
                    state_nxt = RMSC_ST_SHIFT;
                    count_nxt = 5'h00;
                end
                RMSC_ST_SHIFT: begin
                    if (rise) begin
                        shift_nxt = {shift_r[22:0], i_spi_sdio};
                        count_nxt = count_r + 5'h01;
                        if (count_r == 5'(7) && shift_r[6]) begin
                            state_nxt = RMSC_ST_DRIVE;
                        end
                        // Only the 24th edge commits; short frames are dropped
                        if (count_r == 5'(RMSC_FRAME_BITS - 1) && !shift_r[22]) begin
                            commit_nxt = 1'b1;
                        end
                    end
                end
                RMSC_ST_DRIVE: begin
                    if (fall) begin
                        if (count_r == 5'(RMSC_FRAME_BITS)) begin
                            // Last bit stands until its falling edge, then the pin is let go
                            state_nxt = RMSC_ST_IDLE;
                        end else if (count_r == 5'(8)) begin
                            out_nxt = rmux[15];
                            rd_nxt = {rmux[14:0], 1'b0};
                        end else begin
                            out_nxt = rd_r[15];
                            rd_nxt = {rd_r[14:0], 1'b0};
                        end
                    end
                    if (rise && count_r != 5'(RMSC_FRAME_BITS)) begin
                        count_nxt = count_r + 5'h01;
                    end
                end
                default: state_nxt = RMSC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= RMSC_ST_IDLE;
            sclk_d_r <= 1'b0;
            count_r <= 5'h00;
            shift_r <= 24'h000000;
            rd_r <= 16'h0000;
            out_r <= 1'b0;
            commit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sclk_d_r <= sclk_d_nxt;
            count_r <= count_nxt;
            shift_r <= shift_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            commit_r <= commit_nxt;
        end
    end

    always_comb begin
        pwr_nxt = pwr_r;
        int_nxt = int_r;
        frac_nxt = frac_r;
        mod_nxt = mod_r;
        pump_nxt = pump_r;
        ref_nxt = ref_r;
        osc_nxt = osc_r;
        rfin_nxt = rfin_r;
        soft_nxt = 1'b0;
        if (soft_r) begin
            // Soft reset returns every register to its power-on value
            pwr_nxt = RMSC_RST_POWER;
            int_nxt = RMSC_RST_INT;
            frac_nxt = RMSC_RST_FRAC;
            mod_nxt = RMSC_RST_MOD;
            pump_nxt = RMSC_RST_PUMP;
            ref_nxt = RMSC_RST_REF;
            osc_nxt = RMSC_RST_OSC;
            rfin_nxt = RMSC_RST_RFIN;
        end else if (commit_r) begin
            case (addr)
                RMSC_OFS_SOFT_RESET: soft_nxt = wdata[RMSC_B_SOFT_RESET];
                RMSC_OFS_POWER: pwr_nxt = wdata;
                RMSC_OFS_INT: int_nxt = wdata;
                RMSC_OFS_FRAC: frac_nxt = wdata;
                RMSC_OFS_MOD: mod_nxt = wdata;
                RMSC_OFS_PUMP: pump_nxt = wdata;
                RMSC_OFS_REF: ref_nxt = wdata;
                RMSC_OFS_OSC: osc_nxt = wdata;
                RMSC_OFS_RFIN: rfin_nxt = wdata;
                default: soft_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pwr_r <= RMSC_RST_POWER;
            int_r <= RMSC_RST_INT;
            frac_r <= RMSC_RST_FRAC;
            mod_r <= RMSC_RST_MOD;
            pump_r <= RMSC_RST_PUMP;
            ref_r <= RMSC_RST_REF;
            osc_r <= RMSC_RST_OSC;
            rfin_r <= RMSC_RST_RFIN;
            soft_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            int_r <= int_nxt;
            frac_r <= frac_nxt;
            mod_r <= mod_nxt;
            pump_r <= pump_nxt;
            ref_r <= ref_nxt;
            osc_r <= osc_nxt;
            rfin_r <= rfin_nxt;
            soft_r <= soft_nxt;
        end
    end

    assign o_spi_sdio = out_r;
    assign o_spi_sdio_oe_n = (state_r != RMSC_ST_DRIVE) || (count_r < 5'(9));
    assign o_soft_reset = soft_r;

    // Power outputs straight from register bits
    assign o_power.lo_regulator_power = pwr_r[RMSC_B_LO_REG];
    assign o_power.if_amp_power = pwr_r[RMSC_B_IF_AMP];
    assign o_power.mixer_power = pwr_r[RMSC_B_MIXER];
    assign o_power.external_lo_path_power = pwr_r[RMSC_B_EXT_LO];
    assign o_power.lo_driver_power = pwr_r[RMSC_B_LO_DRV];
    assign o_power.reference_buffer_power = pwr_r[5];
    assign o_power.oscillator_power = pwr_r[4];
    assign o_power.divider_power = pwr_r[3];
    assign o_power.pump_power = pwr_r[2];
    assign o_power.oscillator_regulator_power = pwr_r[1];
    assign o_power.main_regulator_power = pwr_r[0];

    assign o_divider.integer_mode = int_r[RMSC_B_DIV_MODE];
    assign o_divider.integer_word = int_r[10:0];
    assign o_divider.fraction_numerator_word = frac_r[10:0];
    assign o_divider.modulus_word = mod_r[10:0];

    assign o_synth.pump_coarse_current = pump_r[13:10];
    assign o_synth.bleed_source = pump_r[RMSC_B_BLEED_DIR];
    assign o_synth.bleed_step = pump_r[4:0];
    assign o_synth.reference_output_select = ref_r[6:4];
    assign o_synth.detector_polarity = ref_r[RMSC_B_POLARITY];
    assign o_synth.reference_input_scale = ref_r[2:0];
    assign o_synth.lo_drive_amplitude = osc_r[8:7];
    assign o_synth.lo_output_divide = osc_r[4:3];
    assign o_synth.lo_source_select = osc_r[2:0];

    assign o_rfin.input_switch_control_source = rfin_r[RMSC_B_SW_SRC];
    assign o_rfin.input_switch_select = rfin_r[10:9];
    assign o_rfin.rf_attenuation_step = rfin_r[8:5];
    assign o_rfin.if_attenuation_step = rfin_r[4:0];
    assign o_rf_input_active = rfin_r[RMSC_B_SW_SRC] ? i_switch_pins : rfin_r[10:9];

    a_commit_full: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        commit_r |-> $past(count_r) == 5'(RMSC_FRAME_BITS - 1))
        else $error("commit without full frame");
    a_power_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_POWER && !soft_r) |=> pwr_r == $past(wdata))
        else $error("power write lost");
    a_soft_restore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        soft_r |=> pwr_r == RMSC_RST_POWER && osc_r == RMSC_RST_OSC && pump_r == RMSC_RST_PUMP)
        else $error("soft reset missed");
    a_soft_cause: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(soft_r) |-> $past(commit_r) && $past(addr) == RMSC_OFS_SOFT_RESET)
        else $error("spurious soft reset");
    a_int_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !commit_r && !soft_r |=> $stable(int_r) && $stable(rfin_r))
        else $error("register changed without write");
    a_div_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_INT && !soft_r) |=> o_divider.integer_mode == $past(wdata[11]))
        else $error("divide mode write lost");
    a_switch_src: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !rfin_r[RMSC_B_SW_SRC] |-> o_rf_input_active == rfin_r[10:9])
        else $error("switch source wrong");
    a_pump_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_PUMP && !soft_r) |=> o_synth.bleed_step == $past(wdata[4:0]))
        else $error("pump write lost");
    a_soft_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        soft_r |=> !soft_r)
        else $error("soft reset pulse too long");
    a_frac_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_FRAC && !soft_r) |=> frac_r == $past(wdata))
        else $error("fraction write lost");
    a_osc_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_OSC && !soft_r) |=> osc_r == $past(wdata))
        else $error("oscillator write lost");
    a_rfin_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (commit_r && addr == RMSC_OFS_RFIN && !soft_r) |=> rfin_r == $past(wdata))
        else $error("input config write lost");
    a_pins_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rfin_r[RMSC_B_SW_SRC] |-> o_rf_input_active == i_switch_pins)
        else $error("switch ignores pins");

    c_write: cover property (@(posedge i_ref_clk) commit_r && addr == RMSC_OFS_OSC);
    c_soft: cover property (@(posedge i_ref_clk) soft_r);
    c_read: cover property (@(posedge i_ref_clk) !o_spi_sdio_oe_n);
    c_pins: cover property (@(posedge i_ref_clk) rfin_r[RMSC_B_SW_SRC] && o_rf_input_active == 2'h3);

endmodule : rmsc_regs

/* File: testbench/rmsc_host.sv */
`timescale 1ns/1ps
module rmsc_host (
    input wire logic i_ref_clk,
    input wire logic i_dev_sdio,
    input wire logic i_dev_oe_n,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdio
);
    logic drv;
    logic bit_r;
    logic last;
    // Released line shows the inverse of its last level, never a held copy
    assign o_sdio = !i_dev_oe_n ? i_dev_sdio : (drv ? bit_r : !last);
    always @(posedge i_ref_clk) last <= o_sdio;
    initial begin
        o_sclk = 0;
        o_cs_n = 1;
        drv = 0;
        bit_r = 0;
        last = 0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : wait_clk
    // Sends the first nbits bits of the frame; a short count is used on purpose to test refusal
    task automatic frame(input logic rd, input logic [6:0] adr, input logic [15:0] dat,
                         input int nbits, output logic [15:0] q);
        logic [23:0] w;
        w = {rd, adr, dat};
        q = 16'h0000;
        o_cs_n = 0;
        wait_clk(4);
        for (int i = 0; i < nbits; i++) begin
            drv = (i < 8) || !rd;
            bit_r = w[23 - i];
            wait_clk(4);
            o_sclk = 1;
            wait_clk(4);
            if (rd && i >= 8) q = {q[14:0], o_sdio};
            o_sclk = 0;
        end
        drv = 0;
        wait_clk(4);
        o_cs_n = 1;
        wait_clk(8);
    endtask : frame
endmodule : rmsc_host

/* File: testbench/rmsc_regs_bench.sv */
`timescale 1ns/1ps
module rmsc_regs_bench;
    import rmsc_pkg::*;
    logic i_ref_clk = 0;
    logic i_rst = 1;
    logic [1:0] i_switch_pins = 2'h0;
    logic sclk, cs_n, sdio_w, o_spi_sdio, o_spi_sdio_oe_n, o_soft_reset;
    rmsc_power_t o_power;
    rmsc_divider_t o_divider;
    rmsc_synth_t o_synth;
    rmsc_rfin_t o_rfin;
    logic [1:0] o_rf_input_active;
    int failures = 0;
    int cmp_count = 0;
    int pulses = 0;
    logic [15:0] q;
    logic [15:0] mdl [9];
    localparam logic [7:0] OFS [9] = '{RMSC_OFS_SOFT_RESET, RMSC_OFS_POWER, RMSC_OFS_INT,
        RMSC_OFS_FRAC, RMSC_OFS_MOD, RMSC_OFS_PUMP, RMSC_OFS_REF, RMSC_OFS_OSC, RMSC_OFS_RFIN};
    localparam logic [15:0] RST [9] = '{16'h0000, RMSC_RST_POWER, RMSC_RST_INT, RMSC_RST_FRAC,
        RMSC_RST_MOD, RMSC_RST_PUMP, RMSC_RST_REF, RMSC_RST_OSC, RMSC_RST_RFIN};
    localparam logic [15:0] MSK [9] = '{16'h0000, 16'h8BBF, 16'h0FFF, 16'h07FF, 16'h07FF,
        16'h3C3F, 16'h007F, 16'h019F, 16'h0FFF};
    localparam logic [3:0] THERMO [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
    localparam logic [2:0] REFOUT [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};

    always #12.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (o_soft_reset === 1'b1) pulses++;

    rmsc_host host (.i_ref_clk(i_ref_clk), .i_dev_sdio(o_spi_sdio),
        .i_dev_oe_n(o_spi_sdio_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio_w));
    rmsc_regs uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n), .i_spi_sdio(sdio_w), .i_switch_pins(i_switch_pins),
        .o_spi_sdio(o_spi_sdio), .o_spi_sdio_oe_n(o_spi_sdio_oe_n),
        .o_soft_reset(o_soft_reset), .o_power(o_power), .o_divider(o_divider),
        .o_synth(o_synth), .o_rfin(o_rfin), .o_rf_input_active(o_rf_input_active));

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic check_ports;
        logic [1:0] sw;
        sw = mdl[8][11] ? i_switch_pins : mdl[8][10:9];
        check(64'(o_power[10]), 64'(mdl[1][15]), "lo regulator");
        check(64'(o_power[9]), 64'(mdl[1][11]), "if amp");
        check(64'(o_power[8:6]), 64'(mdl[1][9:7]), "mixer lo path");
        check(64'(o_power[5:0]), 64'(mdl[1][5:0]), "blocks");
        check(64'(o_divider[33:22]), 64'(mdl[2][11:0]), "integer");
        check(64'(o_divider[21:11]), 64'(mdl[3][10:0]), "fraction");
        check(64'(o_divider[10:0]), 64'(mdl[4][10:0]), "modulus");
        check(64'(o_synth[23:20]), 64'(mdl[5][13:10]), "coarse");
        check(64'(o_synth[19:14]), 64'(mdl[5][5:0]), "bleed");
        check(64'(o_synth[13:7]), 64'(mdl[6][6:0]), "reference");
        check(64'(o_synth[6:5]), 64'(mdl[7][8:7]), "drive");
        check(64'(o_synth[4:0]), 64'(mdl[7][4:0]), "divide source");
        check(64'(o_rfin), 64'(mdl[8][11:0]), "rfin");
        check(64'(o_rf_input_active), 64'(sw), "switch");
    endtask : check_ports
    // Keep fields inside their legal codes and reserved bits at reset level
    function automatic logic [15:0] fix(input int k, input logic [15:0] v);
        v = (v & MSK[k]) | (RST[k] & ~MSK[k]);
        if (k == 5) v[13:10] = THERMO[v[11:10]];
        if (k == 6) v[6:0] = {REFOUT[v[6:4] % 6], v[3], 3'(v[2:0] % 5)};
        if (k == 8) v[4:0] = 5'(v[4:0] % 25);
        return v;
    endfunction : fix
    task automatic model_reset;
        for (int k = 0; k < 9; k++) mdl[k] = RST[k];
    endtask : model_reset
    task automatic wr(input int k, input logic [15:0] v);
        host.frame(1'b0, OFS[k][6:0], v, 24, q);
        if (k > 0) mdl[k] = v;
    endtask : wr
    task automatic rd(input int k);
        host.frame(1'b1, OFS[k][6:0], 16'h0000, 24, q);
        check(64'(q & MSK[k]), 64'(mdl[k] & MSK[k]), "read");
    endtask : rd
    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask : test_end

    initial begin
        #2000000;
        failures++;
        wrap_up();
    end

    initial begin
        int p;
        model_reset();
        void'($urandom(32'hC9242C4E));
        host.wait_clk(4);
        i_rst = 0;
        host.wait_clk(2);
        check_ports();
        for (int k = 1; k < 9; k++) rd(k);
        test_end("reset values");
        repeat (3) begin
            for (int k = 1; k < 9; k++) begin
                i_switch_pins = 2'($urandom);
                wr(k, fix(k, 16'($urandom)));
                check_ports();
                rd(k);
            end
        end
        test_end("random writes");
        for (int i = 0; i < 8; i++) begin
            wr(5, fix(5, {4'h0, 2'(i), 4'h0, i[0], 5'(i * 3)}));
            wr(6, fix(6, {9'h000, 3'(i), i[0], 3'(i)}));
            wr(7, {7'h00, 2'(i), 2'b00, 2'(i), 3'(i)});
            check_ports();
        end
        test_end("code sweep");
        wr(8, mdl[8] | 16'h0800);
        for (int i = 0; i < 4; i++) begin
            i_switch_pins = 2'(i);
            host.wait_clk(1);
            check_ports();
        end
        test_end("pin control");
        host.frame(1'b0, OFS[2][6:0], ~mdl[2], 12, q);
        host.frame(1'b0, 7'h10, 16'hFFFF, 24, q);
        check_ports();
        host.frame(1'b1, 7'h10, 16'h0000, 24, q);
        check(64'(q), 64'h0, "unmapped");
        test_end("refused frames");
        p = pulses;
        wr(0, 16'hFFFE);
        check(64'(pulses - p), 64'h0, "no pulse");
        wr(0, 16'h0001);
        check(64'(pulses - p), 64'h1, "pulse");
        host.frame(1'b1, OFS[0][6:0], 16'h0000, 24, q);
        check(64'(q), 64'h0, "reset word reads zero");
        model_reset();
        check_ports();
        test_end("soft reset");
        wr(1, fix(1, 16'($urandom)));
        i_rst = 1;
        host.wait_clk(2);
        i_rst = 0;
        model_reset();
        host.wait_clk(1);
        check_ports();
        rd(1);
        test_end("second reset");
        wrap_up();
    end
endmodule : rmsc_regs_bench
